/* File: core/mier_readout.sv */
/*
  Memory integrity monitor readout: mode sequencer, serial event
  fetch from the memories and the APB register window.
  Assumes an APB master on sys_clk and memories that shift one event
  frame, first bit first, while fetchReq is high.
*/
`timescale 1ns/1ns

// Functional notes
// - Info and index valid only in capture
// - Bit 31 marks parity or uncorrectable
// - Bit 30 marks a successful correction
// - Repeated uncorrectable keeps newest, sets bit 29
// - Uncorrectable lost during transfer sets bit 29
// - Uncorrectable beats correction, bit 28 shows displacement
// - Bit 28 with correction means several corrections
// - Bit 28 alone means correction lost
// - Failing address sits in bits 27:0
// - Memory index in bits 15:0, from one
// - Transition_trigger bit starts transition, reads busy
// - Rest goes capture if pending, first watch
// - Capture repeats or watches, watch rests
// - Pending bit reads one only in watch
module mier_readout (
  input  wire logic                         sys_clk,
  input  wire logic                         nrst,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [mier_pkg::APB_AW-1:0]  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic                              pready,
  output logic      [31:0]                  prdata,
  output logic                              pslverr,
  input  wire logic                         memPending,
  input  wire logic                         serValid,
  input  wire logic                         serData,
  input  wire logic                         indErr,
  input  wire logic                         indCor,
  output logic                              fetchReq
);

  typedef struct packed {
    mier_pkg::mier_state_e          st;
    logic                           seen;
    logic [mier_pkg::CNT_W-1:0]     cnt;
    logic [mier_pkg::FRM_LEN-1:0]   sh;
    logic                           fetch;
    logic                           done;
    logic                           clr;
    logic                           pready;
    logic                           pslverr;
    logic [31:0]                    prdata;
  } mier_ctl_s;

  mier_ctl_s r;
  mier_ctl_s n;

  logic [31:0]                 infoWord;
  logic [mier_pkg::IDX_W-1:0]  idxWord;
  logic                        busy;
  logic                        setup;
  logic                        access;
  logic                        act;
  logic [31:0]                 statWord;
  logic [31:0]                 rdWord;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic logic mier_is_reg(input logic [mier_pkg::APB_AW-1:0] a,
                                       input logic [mier_pkg::APB_AW-1:0] ofs);
    mier_is_reg = (a == ofs);
  endfunction : mier_is_reg

  function automatic logic mier_mapped(input logic [mier_pkg::APB_AW-1:0] a);
    mier_mapped = mier_is_reg(a, mier_pkg::CTRL_OFS) || mier_is_reg(a, mier_pkg::STAT_OFS) ||
                  mier_is_reg(a, mier_pkg::INFO_OFS) || mier_is_reg(a, mier_pkg::IDX_OFS);
  endfunction : mier_mapped

  // ------------------------------------------------------------
  // Bus phases
  // ------------------------------------------------------------
  assign busy   = (r.st == mier_pkg::ST_FETCH) || (r.st == mier_pkg::ST_TOWATCH) ||
                  (r.st == mier_pkg::ST_TOREST);
  assign setup  = psel && !penable;
  assign access = psel && penable && r.pready;
  // Activation while already busy is dropped: the bit is one-shot
  assign act    = access && pwrite && mier_is_reg(paddr, mier_pkg::CTRL_OFS) &&
                  pwdata[mier_pkg::ACT_BIT] && !busy;

  always_comb begin
    statWord = mier_pkg::WORD_ZERO;
    statWord[mier_pkg::STAT_BUSY]  = busy;
    statWord[mier_pkg::STAT_IDLE]  = (r.st == mier_pkg::ST_REST);
    statWord[mier_pkg::STAT_DET]   = (r.st == mier_pkg::ST_CAPT);
    statWord[mier_pkg::STAT_WATCH] = (r.st == mier_pkg::ST_WATCH);
    statWord[mier_pkg::STAT_PEND]  = (r.st == mier_pkg::ST_WATCH) && memPending;
  end

  always_comb begin
    rdWord = mier_pkg::WORD_ZERO;
    if (mier_is_reg(paddr, mier_pkg::CTRL_OFS)) begin
      rdWord[mier_pkg::ACT_BIT] = busy;
    end else if (mier_is_reg(paddr, mier_pkg::STAT_OFS)) begin
      rdWord = statWord;
    end else if (mier_is_reg(paddr, mier_pkg::INFO_OFS)) begin
      // Stale record is hidden outside capture so software cannot misuse it
      rdWord = (r.st == mier_pkg::ST_CAPT) ? infoWord : mier_pkg::WORD_ZERO;
    end else if (mier_is_reg(paddr, mier_pkg::IDX_OFS)) begin
      if (r.st == mier_pkg::ST_CAPT) begin
        rdWord[mier_pkg::IDX_W-1:0] = idxWord;
      end
    end
  end

  // ------------------------------------------------------------
  // Sequencer, serial fetch and bus answer
  // ------------------------------------------------------------
  always_comb begin
    n      = r;
    n.done = 1'b0;
    n.clr  = 1'b0;

    // One wait-free access phase; a write lands at the access edge
    if (setup) begin
      n.pready  = 1'b1;
      n.pslverr = !mier_mapped(paddr);
      n.prdata  = pwrite ? mier_pkg::WORD_ZERO : rdWord;
    end else if (access) begin
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
    end

    case (r.st)
      mier_pkg::ST_REST: begin
        if (act) begin
          n.seen = 1'b1;
          // The very first activation skips detection
          if (r.seen && memPending) begin
            n.st    = mier_pkg::ST_FETCH;
            n.fetch = 1'b1;
            n.cnt   = mier_pkg::CNT_ZERO;
          end else begin
            n.st = mier_pkg::ST_TOWATCH;
          end
        end
      end
      mier_pkg::ST_CAPT: begin
        if (act) begin
          if (memPending) begin
            n.st    = mier_pkg::ST_FETCH;
            n.fetch = 1'b1;
            n.cnt   = mier_pkg::CNT_ZERO;
          end else begin
            n.st = mier_pkg::ST_TOWATCH;
          end
        end
      end
      mier_pkg::ST_WATCH: begin
        if (act) begin
          n.st  = mier_pkg::ST_TOREST;
          n.clr = 1'b1;
        end
      end
      mier_pkg::ST_FETCH: begin
        if (r.done) begin
          n.st = mier_pkg::ST_CAPT;
        end else if (r.fetch && serValid) begin
          n.sh  = {r.sh[mier_pkg::FRM_LEN-2:0], serData};
          n.cnt = r.cnt + 6'h01;
          if (r.cnt == mier_pkg::CNT_LAST) begin
            n.fetch = 1'b0;
            n.done  = 1'b1;
          end
        end
      end
      mier_pkg::ST_TOWATCH: begin
        n.st = mier_pkg::ST_WATCH;
      end
      mier_pkg::ST_TOREST: begin
        n.st = mier_pkg::ST_REST;
      end
      default: begin
        n.st    = mier_pkg::ST_REST;
        n.fetch = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      r        <= '0;
      r.st     <= mier_pkg::ST_REST;
      r.prdata <= mier_pkg::WORD_ZERO;
    end else begin
      r <= n;
    end
  end

  // ------------------------------------------------------------
  // Event record
  // ------------------------------------------------------------
  mier_event_store u_store (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .clr     (r.clr),
    .frm     (r.done),
    .frmErr  (r.sh[mier_pkg::FRM_ERR]),
    .frmCor  (r.sh[mier_pkg::FRM_COR]),
    .frmAddr (r.sh[mier_pkg::IDX_W +: mier_pkg::ADDR_W]),
    .frmIdx  (r.sh[mier_pkg::IDX_W-1:0]),
    .xfer    (r.fetch),
    .indErr  (indErr),
    .indCor  (indCor),
    .info    (infoWord),
    .idx     (idxWord)
  );

  assign pready   = r.pready;
  assign prdata   = r.prdata;
  assign pslverr  = r.pslverr;
  assign fetchReq = r.fetch;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_INFO_GATE: assert property (@(posedge sys_clk) disable iff (!nrst)
    setup && !pwrite && paddr == mier_pkg::INFO_OFS && r.st != mier_pkg::ST_CAPT |=> prdata == 32'h00000000)
    else $error("event info visible outside capture");
  AST_BUSY_BIT: assert property (@(posedge sys_clk) disable iff (!nrst)
    act |=> busy)
    else $error("activation did not report busy");
  AST_FIRST_WATCH: assert property (@(posedge sys_clk) disable iff (!nrst)
    act && r.st == mier_pkg::ST_REST && !r.seen |=> r.st == mier_pkg::ST_TOWATCH ##1 r.st == mier_pkg::ST_WATCH)
    else $error("first activation did not go to watch");
  AST_CAPT_PEND: assert property (@(posedge sys_clk) disable iff (!nrst)
    act && r.st == mier_pkg::ST_REST && r.seen && memPending |=> fetchReq && r.st == mier_pkg::ST_FETCH)
    else $error("pending event not fetched");
  AST_WATCH_REST: assert property (@(posedge sys_clk) disable iff (!nrst)
    act && r.st == mier_pkg::ST_WATCH |=> ##1 statWord[1] && !busy)
    else $error("watch did not return to rest");
  AST_PEND_STAT: assert property (@(posedge sys_clk) disable iff (!nrst)
    r.st != mier_pkg::ST_WATCH |-> !statWord[4])
    else $error("pending bit outside watch");
  AST_FETCH_DONE: assert property (@(posedge sys_clk) disable iff (!nrst)
    $fell(fetchReq) && r.st == mier_pkg::ST_FETCH |=> r.st == mier_pkg::ST_CAPT && statWord[2])
    else $error("completed frame did not enter capture");
  COV_CAPT: cover property (@(posedge sys_clk) disable iff (!nrst) r.st == mier_pkg::ST_CAPT);
  COV_RECAPT: cover property (@(posedge sys_clk) disable iff (!nrst)
    act && r.st == mier_pkg::ST_CAPT && memPending);
  COV_REST: cover property (@(posedge sys_clk) disable iff (!nrst) act && r.st == mier_pkg::ST_WATCH);

endmodule : mier_readout

/* File: core/mier_pkg.sv */
/*
  Shared constants and types of the memory integrity event readout.
  Assumes a 32-bit APB register window with 12 address bits.
*/
package mier_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int          APB_AW   = 12;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [11:0] INFO_OFS = 12'h008;
  localparam logic [11:0] IDX_OFS  = 12'h00c;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int ACT_BIT    = 0;
  localparam int STAT_BUSY  = 0;
  localparam int STAT_IDLE  = 1;
  localparam int STAT_DET   = 2;
  localparam int STAT_WATCH = 3;
  localparam int STAT_PEND  = 4;
  localparam int INFO_ERR   = 31;
  localparam int INFO_COR   = 30;
  localparam int INFO_EOVF  = 29;
  localparam int INFO_COVF  = 28;
  localparam int ADDR_W     = 28;
  localparam int IDX_W      = 16;

  // ------------------------------------------------------------
  // Serial event frame: error, correction, address, index
  // ------------------------------------------------------------
  localparam int         FRM_LEN  = 2 + ADDR_W + IDX_W;
  localparam int         FRM_ERR  = FRM_LEN - 1;
  localparam int         FRM_COR  = FRM_LEN - 2;
  localparam int         CNT_W    = 6;
  localparam logic [5:0] CNT_LAST = 6'h2d;
  localparam logic [5:0] CNT_ZERO = 6'h00;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  typedef enum logic [2:0] {
    ST_REST    = 3'b000,
    ST_WATCH   = 3'b001,
    ST_CAPT    = 3'b010,
    ST_FETCH   = 3'b011,
    ST_TOWATCH = 3'b100,
    ST_TOREST  = 3'b101
  } mier_state_e;

endpackage : mier_pkg

/* File: core/mier_event_store.sv */
/*
  Recorded event of the integrity monitor with its overflow bookkeeping.
  Assumes complete frames arrive as one-cycle strobes and indication
  pulses are synchronous to sys_clk.
*/
`timescale 1ns/1ns
module mier_event_store (
  input  wire logic                        sys_clk,
  input  wire logic                        nrst,
  input  wire logic                        clr,
  input  wire logic                        frm,
  input  wire logic                        frmErr,
  input  wire logic                        frmCor,
  input  wire logic [mier_pkg::ADDR_W-1:0] frmAddr,
  input  wire logic [mier_pkg::IDX_W-1:0]  frmIdx,
  input  wire logic                        xfer,
  input  wire logic                        indErr,
  input  wire logic                        indCor,
  output logic      [31:0]                 info,
  output logic      [mier_pkg::IDX_W-1:0]  idx
);

  typedef struct packed {
    logic [31:0]                info;
    logic [mier_pkg::IDX_W-1:0] idx;
  } mier_store_s;

  mier_store_s r;
  mier_store_s n;

  // ------------------------------------------------------------
  // Next record
  // ------------------------------------------------------------
  always_comb begin
    n = r;
    if (clr) begin
      n = '0;
    end
    if (frm) begin
      if (frmErr) begin
        if (r.info[mier_pkg::INFO_ERR]) begin
          n.info[mier_pkg::INFO_EOVF] = 1'b1;
        end
        if (r.info[mier_pkg::INFO_COR]) begin
          n.info[mier_pkg::INFO_COVF] = 1'b1;
        end
        n.info[mier_pkg::INFO_ERR] = 1'b1;
        n.info[mier_pkg::INFO_COR] = 1'b0;
        n.info[mier_pkg::ADDR_W-1:0] = frmAddr;
        n.idx = frmIdx;
      end else if (frmCor) begin
        if (r.info[mier_pkg::INFO_ERR]) begin
          n.info[mier_pkg::INFO_COVF] = 1'b1;
        end else begin
          // Newest correction wins the address slot
          n.info[mier_pkg::INFO_COVF] = n.info[mier_pkg::INFO_COVF] | r.info[mier_pkg::INFO_COR];
          n.info[mier_pkg::INFO_COR] = 1'b1;
          n.info[mier_pkg::ADDR_W-1:0] = frmAddr;
          n.idx = frmIdx;
        end
      end
    end
    // Set wins over the clear: a lost event must never vanish
    if (xfer && indErr) begin
      n.info[mier_pkg::INFO_EOVF] = 1'b1;
    end
    if (xfer && indCor) begin
      n.info[mier_pkg::INFO_COVF] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign info = r.info;
  assign idx  = r.idx;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_ERR_SET: assert property (@(posedge sys_clk) disable iff (!nrst)
    frm && frmErr |=> info[31] && info[27:0] == $past(frmAddr))
    else $error("uncorrectable frame not recorded");
  AST_EOVF: assert property (@(posedge sys_clk) disable iff (!nrst)
    frm && frmErr && info[31] && !clr |=> info[29] && info[31])
    else $error("repeated uncorrectable event without overflow");
  AST_XFER_OVF: assert property (@(posedge sys_clk) disable iff (!nrst)
    xfer && indErr |=> info[29])
    else $error("lost uncorrectable event not flagged");
  AST_COR_DROP: assert property (@(posedge sys_clk) disable iff (!nrst)
    frm && frmCor && !frmErr && info[31] && !clr |=> info[28] && $stable(info[27:0]))
    else $error("correction displaced an uncorrectable record");
  AST_COR_SET: assert property (@(posedge sys_clk) disable iff (!nrst)
    frm && frmCor && !frmErr && !info[31] && !clr |=> info[30] && idx == $past(frmIdx))
    else $error("correction not recorded");
  COV_EOVF: cover property (@(posedge sys_clk) disable iff (!nrst) info[31] && info[29]);

endmodule : mier_event_store

/* File: verification/mier_mem_model.sv */
/*
  Behavioural memory side of the integrity monitor: one event frame at a time.
  Assumes the testbench loads a frame and raises the indication requests.
*/
`timescale 1ns/1ns
module mier_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        load,
  input  wire logic [45:0] frmIn,
  input  wire logic        slow,
  input  wire logic        errIn,
  input  wire logic        corIn,
  input  wire logic        fetchReq,
  output logic             memPending,
  output logic             serValid,
  output logic             serData,
  output logic             indErr,
  output logic             indCor
);
  // ------------------------------------------------------------
  // Frame shifter
  // ------------------------------------------------------------
  logic [45:0] sh;
  logic [5:0]  cnt;
  logic        gap;
  always @(posedge sys_clk or negedge nrst) begin : drv
    logic [45:0] nsh;
    logic [5:0]  ca;
    logic        nv;
    if (!nrst) begin
      {sh, cnt, gap, memPending, serValid, serData, indErr, indCor} <= '0;
    end else begin
      nsh = serValid ? {sh[44:0], 1'b0} : sh;
      ca = cnt + 6'(serValid);
      // Slow mode leaves every other cycle empty
      nv = fetchReq && memPending && ca < 6'h2e && !(slow && gap);
      gap <= ~gap;
      indErr <= errIn;
      indCor <= corIn;
      serValid <= nv;
      // An idle line toggles so a stale bit is never mistaken for data
      serData <= nv ? nsh[45] : ~serData;
      sh <= load ? frmIn : nsh;
      cnt <= load ? 6'h00 : ca;
      memPending <= load | (memPending & (ca < 6'h2e));
    end
  end
endmodule : mier_mem_model

/* File: verification/testbench.sv */
/*
  Self-checking testbench of the integrity event readout over APB.
  Assumes mier_readout and the memory model; fixed seed for repeatability.
*/
`timescale 1ns/1ns
module testbench;
  logic                        sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [mier_pkg::APB_AW-1:0] paddr = '0;
  logic [31:0]                 pwdata = '0, prdata, rd, xInfo, b0;
  logic                        pready, pslverr, memPending, serValid, serData, indErr, indCor, fetchReq;
  logic                        load = 0, slow = 0, errIn = 0, corIn = 0, er;
  logic [45:0]                 frmIn = '0, frmM = '0;
  logic [15:0]                 xIdx;
  int                          err_count = 0, checked = 0, st = 0;
  bit                          first = 1, pendM = 0;

  mier_readout mier_readout_i (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .memPending(memPending), .serValid(serValid), .serData(serData),
    .indErr(indErr), .indCor(indCor), .fetchReq(fetchReq));
  mier_mem_model mier_mem_model_i (.sys_clk(sys_clk), .nrst(nrst), .load(load), .frmIn(frmIn),
    .slow(slow), .errIn(errIn), .corIn(corIn), .fetchReq(fetchReq), .memPending(memPending),
    .serValid(serValid), .serData(serData), .indErr(indErr), .indCor(indCor));

  always #10 sys_clk = ~sys_clk;

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task complete_run;
    $display("Mismatches %0d, checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task apb(input logic wr, input logic [mier_pkg::APB_AW-1:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk({31'h0, pready}, 32'h1, "pready timeout");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task regs;
    logic [31:0] m;
    m = (st == 2 && xInfo[31:30] == 2'b00) ? 32'hf0000000 : 32'hffffffff;
    apb(0, mier_pkg::STAT_OFS, '0);
    chk(rd, st == 0 ? 32'h2 : st == 1 ? {27'h0, pendM, 4'h8} : 32'h4, "status");
    apb(0, mier_pkg::INFO_OFS, '0);
    chk(rd & m, (st == 2 ? xInfo : 32'h0) & m, "info");
    apb(0, mier_pkg::IDX_OFS, '0);
    chk(rd & m, (st == 2 ? {16'h0, xIdx} : 32'h0) & m, "index");
  endtask : regs

  // Expected record: err beats cor, repeats and losses raise the overflow bits
  task step(input logic ld, e, c, sl, ie, ic, one);
    logic [27:0] a;
    logic [15:0] ix;
    int          nst, n;
    a = 28'($urandom);
    ix = one ? 16'h1 : 16'($urandom % 32'hffff) + 16'h1;
    if (ld) begin
      load <= 1'b1;
      frmM = {e, c, a, ix};
      frmIn <= frmM;
      slow <= sl;
      @(posedge sys_clk);
      load <= 1'b0;
      pendM = 1;
    end
    nst = (st == 1) ? 0 : (pendM && !(st == 0 && first)) ? 2 : 1;
    first = 0;
    if (st == 1) begin
      xInfo = '0;
      xIdx = '0;
    end
    apb(1, mier_pkg::CTRL_OFS, 32'h1);
    if (nst == 2) begin
      n = 0;
      while (fetchReq !== 1'b1 && n < 20) begin
        @(posedge sys_clk);
        n++;
      end
      chk({31'h0, fetchReq}, 32'h1, "fetch request");
      errIn <= ie;
      corIn <= ic;
      @(posedge sys_clk);
      errIn <= 1'b0;
      corIn <= 1'b0;
      // The frame in the memory may have been loaded by an earlier step
      {e, c, a, ix} = frmM;
      if (e && xInfo[31]) xInfo[29] = 1'b1;
      if ((e && xInfo[30]) || (!e && c && (xInfo[31] || xInfo[30]))) xInfo[28] = 1'b1;
      if (e || (c && !xInfo[31])) begin
        xInfo[27:0] = a;
        xIdx = ix;
      end
      if (e) xInfo[31:30] = 2'b10;
      else if (c && !xInfo[31]) xInfo[30] = 1'b1;
      xInfo[29] = xInfo[29] | ie;
      xInfo[28] = xInfo[28] | ic;
      pendM = 0;
    end
    apb(0, mier_pkg::CTRL_OFS, '0);
    chk(rd, nst == 2 ? 32'h1 : 32'h0, "transition_trigger readback");
    n = 0;
    do begin
      apb(0, mier_pkg::STAT_OFS, '0);
      if (n == 0) b0 = rd;
      n++;
    end while (rd[0] === 1'b1 && n < 200);
    if (n >= 200) chk({31'h0, rd[0]}, 32'h0, "busy stuck");
    if (nst == 2) chk(b0, 32'h1, "busy during fetch");
    st = nst;
    regs;
  endtask : step

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h304c));
    xInfo = '0;
    xIdx = '0;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    apb(1, mier_pkg::INFO_OFS, 32'hffffffff);
    regs;
    apb(0, 12'h010, '0);
    chk({31'h0, er}, 32'h1, "unmapped error");
    step(1, 0, 1, 0, 0, 0, 0);
    step(0, 0, 0, 0, 0, 0, 0);
    step(0, 0, 0, 0, 0, 0, 0);
    step(1, 1, 0, 0, 0, 0, 0);
    step(1, 1, 0, 1, 1, 1, 0);
    repeat (2) step(0, 0, 0, 0, 0, 0, 0);
    step(1, 0, 1, 0, 0, 0, 1);
    step(1, 0, 1, 1, 0, 0, 0);
    repeat (2) step(0, 0, 0, 0, 0, 0, 0);
    step(1, 0, 0, 1, 0, 1, 0);
    repeat (2) step(0, 0, 0, 0, 0, 0, 0);
    step(1, 0, 0, 1, 1, 0, 0);
    repeat (6) step(1, 1'($urandom), 1'($urandom), 1'($urandom), 0, 0, 0);
    complete_run;
  end

  // Far longer than the whole sequence needs
  initial begin
    #1000000;
    err_count++;
    complete_run;
  end
endmodule : testbench
